// *** src/dpem_pkg.sv ***
// Shared constants of the second PLL event and reference monitor status bank
package dpem_pkg;
  // ----------------------------------------------------------------
  // Widths and counts
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int EVT_W = 4;
  localparam int NUM_PAIRS = 3;
  localparam int NUM_REFS = 6;
  localparam int REF_SEL_W = 3;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_EVT = 8'h04;
  localparam logic [7:0] ADDR_MON_BASE = 8'h05;
  localparam logic [7:0] ADDR_MASK = 8'h0b;
  localparam logic [7:0] ADDR_EVT_CLR = 8'h0c;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_LOCK = 0;
  localparam int BIT_LOST = 1;
  localparam int BIT_HOLD = 2;
  localparam int BIT_REFSW = 3;
  localparam int MON_SCM = 0;
  localparam int MON_CFM = 1;
  localparam int MON_GST = 2;
  localparam int MON_PFM = 3;
  localparam int ODD_SHIFT = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_EVT = 4'h0;
  localparam logic [2:0] RST_REF_SEL = 3'h0;
endpackage

// *** src/dpem_stk_if.sv ***
// Interface between a sticky status bank and its user
`timescale 1ns/1ps
interface dpem_stk_if #(
  parameter int W = 8
);
  logic [W-1:0] set_ev;
  logic [W-1:0] clr;
  logic [W-1:0] q;
  modport bank (input set_ev, input clr, output q);
  modport user (output set_ev, output clr, input q);
endinterface

// *** src/dpem_sticky.sv ***
// Bank of sticky status bits, set by hardware and cleared by the user
`timescale 1ns/1ps
module dpem_sticky
  import dpem_pkg::*;
#(
  parameter int W = 8
) (
  // Clock and reset
  input logic clk,
  input logic rst,
  // Set, clear and state
  dpem_stk_if.bank st
);
  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;

  // Set is applied after clear so a coincident event is never lost
  always_comb begin
    q_next = (q_reg & ~st.clr) | st.set_ev;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

  assign st.q = q_reg;

  a_set_wins_clear: assert property (
    @(posedge clk) disable iff (rst)
    (st.set_ev != '0) |=> ((st.q & $past(st.set_ev)) == $past(st.set_ev)))
    else $error("sticky bit lost an event");

  a_bits_stay_set: assert property (
    @(posedge clk) disable iff (rst)
    1'b1 |=> ((st.q & ($past(st.q) & ~$past(st.clr))) == ($past(st.q) & ~$past(st.clr))))
    else $error("sticky bit dropped without a clear");
endmodule

// *** src/dpem_top.sv ***
// Second PLL event register, reference monitor failure registers and interrupt
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Overview of operation
// - Bit 0 set when PLL achieves lock
// - Bit 1 set when PLL loses lock
// - Bit 2 set when PLL enters holdover
// - Bit 3 set on reference switch
// - Event bits held until cleared by a read or by a one written to the clear register
// - Single-cycle monitor failure in bits 0/4
// - Coarse frequency failure in bits 1/5
// - Guard soak failure in bits 2/6
// - Precise frequency failure in bits 3/7
// - Mask bit one lets event interrupt through
// ------------------------------------------------------------------
module dpem_top
  import dpem_pkg::*;
(
  // Clock and reset
  input logic clk,
  input logic rst,
  // Register port
  input logic [ADDR_W-1:0] addr,
  input logic [DATA_W-1:0] wdata,
  input logic wr_en,
  input logic rd_en,
  output logic [DATA_W-1:0] rdata,
  // Second PLL state
  input logic pll_locked,
  input logic pll_holdover,
  input logic [REF_SEL_W-1:0] pll_ref_sel,
  // Reference monitor failure levels, one bit per reference
  input logic [NUM_REFS-1:0] mon_scm_fail,
  input logic [NUM_REFS-1:0] mon_cfm_fail,
  input logic [NUM_REFS-1:0] mon_gst_fail,
  input logic [NUM_REFS-1:0] mon_pfm_fail,
  // Interrupt
  output logic irq
);
  // ----------------------------------------------------------------
  // Edge detection of PLL state
  // ----------------------------------------------------------------
  logic locked_prev_reg;
  logic locked_prev_next;
  logic hold_prev_reg;
  logic hold_prev_next;
  logic [REF_SEL_W-1:0] ref_prev_reg;
  logic [REF_SEL_W-1:0] ref_prev_next;
  logic primed_reg;
  logic primed_next;
  logic [EVT_W-1:0] evt_set;

  // The first cycle after reset only samples, so the power-up value of
  // the reference select is not reported as a switch
  always_comb begin
    locked_prev_next = pll_locked;
    hold_prev_next = pll_holdover;
    ref_prev_next = pll_ref_sel;
    primed_next = 1'b1;
    evt_set = RST_EVT;
    evt_set[BIT_LOCK] = primed_reg & pll_locked & ~locked_prev_reg;
    evt_set[BIT_LOST] = primed_reg & ~pll_locked & locked_prev_reg;
    evt_set[BIT_HOLD] = primed_reg & pll_holdover & ~hold_prev_reg;
    evt_set[BIT_REFSW] = primed_reg & (pll_ref_sel != ref_prev_reg);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      locked_prev_reg <= 1'b0;
      hold_prev_reg <= 1'b0;
      ref_prev_reg <= RST_REF_SEL;
      primed_reg <= 1'b0;
    end else begin
      locked_prev_reg <= locked_prev_next;
      hold_prev_reg <= hold_prev_next;
      ref_prev_reg <= ref_prev_next;
      primed_reg <= primed_next;
    end
  end

  // ----------------------------------------------------------------
  // Event register
  // ----------------------------------------------------------------
  logic rd_evt;
  logic wr_evt_clr;
  logic [EVT_W-1:0] evt_q;

  assign rd_evt = rd_en && (addr == ADDR_EVT);
  assign wr_evt_clr = wr_en && (addr == ADDR_EVT_CLR);

  dpem_stk_if #(.W(EVT_W)) evt_if ();

  assign evt_if.set_ev = evt_set;
  // Read clears all bits; the extra clear register lets a driver that
  // shares the port acknowledge single bits without a read
  assign evt_if.clr = rd_evt ? {EVT_W{1'b1}} : (wr_evt_clr ? wdata[EVT_W-1:0] : RST_EVT);
  assign evt_q = evt_if.q;

  dpem_sticky #(.W(EVT_W)) u_evt (
    .clk(clk),
    .rst(rst),
    .st(evt_if.bank)
  );

  // ----------------------------------------------------------------
  // Reference monitor failure registers
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] mon_val [NUM_PAIRS];

  for (genvar p = 0; p < NUM_PAIRS; p++) begin : g_pair
    logic [DATA_W-1:0] set_v;
    logic rd_mon;

    dpem_stk_if #(.W(DATA_W)) mon_if ();

    always_comb begin
      set_v = RST_BYTE;
      set_v[MON_SCM] = mon_scm_fail[2*p];
      set_v[MON_SCM+ODD_SHIFT] = mon_scm_fail[2*p+1];
      set_v[MON_CFM] = mon_cfm_fail[2*p];
      set_v[MON_CFM+ODD_SHIFT] = mon_cfm_fail[2*p+1];
      set_v[MON_GST] = mon_gst_fail[2*p];
      set_v[MON_GST+ODD_SHIFT] = mon_gst_fail[2*p+1];
      set_v[MON_PFM] = mon_pfm_fail[2*p];
      set_v[MON_PFM+ODD_SHIFT] = mon_pfm_fail[2*p+1];
    end

    assign rd_mon = rd_en && (addr == ADDR_MON_BASE + 8'(p));
    assign mon_if.set_ev = set_v;
    // A fault still present reasserts the bit in the same cycle it is read
    assign mon_if.clr = rd_mon ? {DATA_W{1'b1}} : RST_BYTE;
    assign mon_val[p] = mon_if.q;

    dpem_sticky #(.W(DATA_W)) u_mon (
      .clk(clk),
      .rst(rst),
      .st(mon_if.bank)
    );

    a_even_ref_map: assert property (
      @(posedge clk) disable iff (rst)
      1'b1 |=> ((mon_val[p][MON_SCM] || !$past(mon_scm_fail[2*p]))
        && (mon_val[p][MON_CFM] || !$past(mon_cfm_fail[2*p]))
        && (mon_val[p][MON_GST] || !$past(mon_gst_fail[2*p]))
        && (mon_val[p][MON_PFM] || !$past(mon_pfm_fail[2*p]))))
      else $error("even reference failure not reported");

    a_odd_ref_map: assert property (
      @(posedge clk) disable iff (rst)
      1'b1 |=> ((mon_val[p][MON_SCM+ODD_SHIFT] || !$past(mon_scm_fail[2*p+1]))
        && (mon_val[p][MON_CFM+ODD_SHIFT] || !$past(mon_cfm_fail[2*p+1]))
        && (mon_val[p][MON_GST+ODD_SHIFT] || !$past(mon_gst_fail[2*p+1]))
        && (mon_val[p][MON_PFM+ODD_SHIFT] || !$past(mon_pfm_fail[2*p+1]))))
      else $error("odd reference failure not reported");

    a_mon_read_clears: assert property (
      @(posedge clk) disable iff (rst)
      (rd_mon && (set_v == RST_BYTE)) |=> (mon_val[p] == RST_BYTE))
      else $error("monitor register not cleared by read");
  end

  // ----------------------------------------------------------------
  // Mask register, read port and interrupt
  // ----------------------------------------------------------------
  logic [EVT_W-1:0] mask_reg;
  logic [EVT_W-1:0] mask_next;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic irq_reg;
  logic irq_next;

  always_comb begin
    mask_next = mask_reg;
    if (wr_en && (addr == ADDR_MASK)) begin
      mask_next = wdata[EVT_W-1:0];
    end
    rdata_next = RST_BYTE;
    if (rd_en) begin
      case (addr)
        ADDR_EVT: rdata_next = {{(DATA_W-EVT_W){1'b0}}, evt_q};
        ADDR_MON_BASE: rdata_next = mon_val[0];
        ADDR_MON_BASE + 8'h01: rdata_next = mon_val[1];
        ADDR_MON_BASE + 8'h02: rdata_next = mon_val[2];
        ADDR_MASK: rdata_next = {{(DATA_W-EVT_W){1'b0}}, mask_reg};
        default: rdata_next = RST_BYTE;
      endcase
    end
    // Registered so the pin never glitches while bits change
    irq_next = |(evt_q & mask_reg);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mask_reg <= RST_EVT;
      rdata_reg <= RST_BYTE;
      irq_reg <= 1'b0;
    end else begin
      mask_reg <= mask_next;
      rdata_reg <= rdata_next;
      irq_reg <= irq_next;
    end
  end

  assign rdata = rdata_reg;
  assign irq = irq_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_lock_sets_bit: assert property (
    @(posedge clk) disable iff (rst)
    (primed_reg && $rose(pll_locked)) |=> evt_q[BIT_LOCK])
    else $error("lock event not recorded");

  a_loss_sets_bit: assert property (
    @(posedge clk) disable iff (rst)
    (primed_reg && $fell(pll_locked)) |=> evt_q[BIT_LOST])
    else $error("loss of lock not recorded");

  a_hold_sets_bit: assert property (
    @(posedge clk) disable iff (rst)
    (primed_reg && $rose(pll_holdover)) |=> evt_q[BIT_HOLD])
    else $error("holdover entry not recorded");

  a_switch_sets_bit: assert property (
    @(posedge clk) disable iff (rst)
    (primed_reg && $changed(pll_ref_sel)) |=> evt_q[BIT_REFSW])
    else $error("reference switch not recorded");

  a_evt_read_clears: assert property (
    @(posedge clk) disable iff (rst)
    (rd_evt && (evt_set == RST_EVT)) |=> ((evt_q == RST_EVT) && (rdata[EVT_W-1:0] == $past(evt_q))))
    else $error("event read did not return and clear");

  // Read data stand for one cycle only, so a stale value is never mistaken for a read
  a_rdata_one_cycle: assert property (
    @(posedge clk) disable iff (rst)
    !rd_en |=> (rdata == RST_BYTE))
    else $error("read data present without a read");

  a_evt_held: assert property (
    @(posedge clk) disable iff (rst)
    (evt_q[BIT_LOCK] && !rd_evt && !wr_evt_clr) |=> evt_q[BIT_LOCK] [*1])
    else $error("event bit dropped without a read");

  a_mask_blocks_irq: assert property (
    @(posedge clk) disable iff (rst)
    ((evt_q & mask_reg) == RST_EVT) |=> !irq)
    else $error("interrupt raised for masked events");

  a_mask_passes_irq: assert property (
    @(posedge clk) disable iff (rst)
    ((evt_q & mask_reg) != RST_EVT) |=> irq)
    else $error("interrupt missing for enabled event");
endmodule

// *** verif/test_dpll_event_ref_monitor_status.sv ***
// Self-checking bench for the PLL event and reference monitor status bank
`timescale 1ns/1ps
`define CHK(act, exp) \
  begin \
    total_checks++; \
    if ((act) !== (exp)) begin \
      fails++; \
      $display("mismatch at %0t: got %h expected %h", $time, (act), (exp)); \
    end \
  end

module test_dpll_event_ref_monitor_status;
  import dpem_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus and observation
  // ----------------------------------------------------------------
  logic clk;
  logic rst;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic wr_en;
  logic rd_en;
  logic [DATA_W-1:0] rdata;
  logic pll_locked;
  logic pll_holdover;
  logic [REF_SEL_W-1:0] pll_ref_sel;
  logic [NUM_REFS-1:0] mon [4];
  logic irq;
  int fails = 0;
  int total_checks = 0;

  dpem_top i_dpem_top (
    .clk(clk),
    .rst(rst),
    .addr(addr),
    .wdata(wdata),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .rdata(rdata),
    .pll_locked(pll_locked),
    .pll_holdover(pll_holdover),
    .pll_ref_sel(pll_ref_sel),
    .mon_scm_fail(mon[MON_SCM]),
    .mon_cfm_fail(mon[MON_CFM]),
    .mon_gst_fail(mon[MON_GST]),
    .mon_pfm_fail(mon[MON_PFM]),
    .irq(irq)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Register port tasks
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample there
  task automatic expect_rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask

  task automatic tally_and_finish;
    if (fails == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    addr = 8'h00;
    wdata = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    pll_locked = 1'b0;
    pll_holdover = 1'b0;
    pll_ref_sel = 3'h0;
    for (int m = 0; m < 4; m++) begin
      mon[m] = '0;
    end
    tick(2);
    rst <= 1'b0;
    tick(2);
    // Reset state, read-only event register, unmapped place
    expect_rd(ADDR_EVT, 8'h00);
    expect_rd(ADDR_MASK, 8'h00);
    wr(ADDR_EVT, 8'h0f);
    expect_rd(ADDR_EVT, 8'h00);
    wr(8'h20, 8'hff);
    expect_rd(8'h20, 8'h00);
    expect_rd(ADDR_MASK, 8'h00);
    // PLL events, each read once to see it; lock and reference switch read again to see them cleared
    @(posedge clk) pll_locked <= 1'b1;
    tick(2);
    expect_rd(ADDR_EVT, 8'h01);
    expect_rd(ADDR_EVT, 8'h00);
    @(posedge clk) pll_holdover <= 1'b1;
    tick(2);
    expect_rd(ADDR_EVT, 8'h04);
    @(posedge clk) pll_locked <= 1'b0;
    tick(2);
    expect_rd(ADDR_EVT, 8'h02);
    @(posedge clk) pll_ref_sel <= 3'h5;
    tick(20);
    expect_rd(ADDR_EVT, 8'h08);
    expect_rd(ADDR_EVT, 8'h00);
    // Every monitor of every reference, fault gone before the read
    for (int r = 0; r < NUM_REFS; r++) begin
      for (int m = 0; m < 4; m++) begin
        @(posedge clk) mon[m] <= 6'(1 << r);
        @(posedge clk) mon[m] <= '0;
        tick(2);
        expect_rd(8'(ADDR_MON_BASE + r / 2), 8'(1 << (m + ODD_SHIFT * (r % 2))));
        expect_rd(8'(ADDR_MON_BASE + r / 2), 8'h00);
      end
    end
    // A fault that persists re-sets its bit right after each read
    @(posedge clk) mon[MON_SCM] <= 6'h01;
    tick(2);
    expect_rd(ADDR_MON_BASE, 8'h01);
    expect_rd(ADDR_MON_BASE, 8'h01);
    @(posedge clk) mon[MON_SCM] <= '0;
    expect_rd(ADDR_MON_BASE, 8'h01);
    expect_rd(ADDR_MON_BASE, 8'h00);
    // Interrupt through the mask, clear register and read-clear
    wr(ADDR_MASK, 8'hff);
    expect_rd(ADDR_MASK, 8'h0f);
    wr(ADDR_MASK, 8'h01);
    @(posedge clk) pll_locked <= 1'b1;
    tick(3);
    #1;
    `CHK(irq, 1'b1)
    wr(ADDR_EVT_CLR, 8'h01);
    tick(2);
    #1;
    `CHK(irq, 1'b0)
    @(posedge clk) pll_locked <= 1'b0;
    tick(3);
    #1;
    `CHK(irq, 1'b0)
    wr(ADDR_MASK, 8'h02);
    tick(2);
    #1;
    `CHK(irq, 1'b1)
    expect_rd(ADDR_EVT, 8'h02);
    tick(2);
    #1;
    `CHK(irq, 1'b0)
    // Reset in mid-run with an enabled event pending and holdover high
    @(posedge clk) pll_ref_sel <= 3'h2;
    wr(ADDR_MASK, 8'h08);
    tick(2);
    #1;
    `CHK(irq, 1'b1)
    @(posedge clk) rst <= 1'b1;
    tick(2);
    #1;
    `CHK(irq, 1'b0)
    @(posedge clk) rst <= 1'b0;
    expect_rd(ADDR_EVT, 8'h00);
    expect_rd(ADDR_MASK, 8'h00);
    tally_and_finish();
  end

  // A hang is cut short well beyond the few hundred cycles the tests need
  initial begin
    tick(5000);
    fails++;
    tally_and_finish();
  end
endmodule
